// ==== verilog/pcr_eval.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcr_eval
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic pc_load,
    input wire logic [31:0] pc_load_val,
    input wire logic opc_step,
    input wire logic req_valid,
    input wire pcr_pkg::pcr_req_t req,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output logic req_ready,
    output logic byte_take,
    output logic mem_req,
    output logic [31:0] mem_addr,
    output logic res_valid,
    output pcr_pkg::pcr_res_t res,
    output logic [31:0] program_counter
);
    import pcr_pkg::*;

    // =====================================================
    // State
    // =====================================================
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_EXT,
        ST_INDIR,
        ST_WAIT,
        ST_DONE
    } pcr_state_t;

    pcr_state_t st_r;
    pcr_state_t st_nxt;
    // Live program counter
    logic [31:0] pc_r;
    logic [31:0] pc_nxt;
    // Captured request
    pcr_req_t cur_r;
    pcr_req_t cur_nxt;
    // Total extension length in bytes for the captured request
    logic [3:0] need_r;
    logic [3:0] need_nxt;
    // Registered outputs
    logic req_ready_r;
    logic req_ready_nxt;
    logic mem_req_r;
    logic mem_req_nxt;
    logic [31:0] mem_addr_r;
    logic [31:0] mem_addr_nxt;
    logic res_valid_r;
    logic res_valid_nxt;
    pcr_res_t res_r;
    pcr_res_t res_nxt;

    // Gatherer wiring
    logic g_clear;
    logic g_take;
    logic [63:0] g_acc;
    logic [3:0] g_cnt;
    logic [31:0] disp_ext;
    logic [1:0] disp_log;

    // Mode nibble and register of a specifier
    function automatic logic [3:0] spec_mode(input logic [7:0] s);
        spec_mode = s[PCR_MODE_LSB +: 4];
    endfunction

    function automatic logic [3:0] spec_reg(input logic [7:0] s);
        spec_reg = s[PCR_REG_LSB +: 4];
    endfunction

    // Extension length in bytes for a counter-based specifier
    function automatic logic [3:0] ext_len(input pcr_req_t r);
        logic [3:0] n;
        n = 4'h0;
        if (r.branch)
            n = r.branch_word ? 4'h2 : 4'h1;
        else
        begin
            case (spec_mode(r.spec))
                PCR_MODE_AINC: n = 4'(1 << r.size);
                PCR_MODE_AINC_DEF: n = 4'h4;
                PCR_MODE_BDISP, PCR_MODE_BDISP_DEF: n = 4'h1;
                PCR_MODE_WDISP, PCR_MODE_WDISP_DEF: n = 4'h2;
                PCR_MODE_LDISP, PCR_MODE_LDISP_DEF: n = 4'h4;
                default: n = 4'h0;
            endcase
        end
        ext_len = n;
    endfunction

    // =====================================================
    // Helpers
    // =====================================================
    // Displacement width follows the mode or the branch form
    always_comb
    begin
        if (cur_r.branch)
            disp_log = cur_r.branch_word ? 2'h1 : 2'h0;
        else if (spec_mode(cur_r.spec) == PCR_MODE_BDISP
                 || spec_mode(cur_r.spec) == PCR_MODE_BDISP_DEF)
            disp_log = 2'h0;
        else if (spec_mode(cur_r.spec) == PCR_MODE_WDISP
                 || spec_mode(cur_r.spec) == PCR_MODE_WDISP_DEF)
            disp_log = 2'h1;
        else
            disp_log = 2'h2;
    end

    pcr_sext u_sext
    (
        .raw(g_acc[31:0]),
        .nbytes_log(disp_log),
        .ext(disp_ext)
    );

    pcr_gather u_gather
    (
        .clk(clk),
        .nrst(nrst),
        .clear(g_clear),
        .take(g_take),
        .byte_in(byte_data),
        .acc(g_acc),
        .count(g_cnt)
    );

    // =====================================================
    // Next-state logic
    // =====================================================
    always_comb
    begin
        st_nxt = st_r;
        pc_nxt = pc_r;
        cur_nxt = cur_r;
        need_nxt = need_r;
        req_ready_nxt = 1'b0;
        mem_req_nxt = 1'b0;
        mem_addr_nxt = mem_addr_r;
        res_valid_nxt = 1'b0;
        res_nxt = res_r;
        g_clear = 1'b0;
        g_take = 1'b0;
        case (st_r)
            ST_IDLE:
            begin
                req_ready_nxt = 1'b1;
                // Redirect from execute overrides stepping
                if (pc_load)
                    pc_nxt = pc_load_val;
                else if (opc_step)
                    pc_nxt = pc_r + 32'h1;
                else if (req_valid && req_ready_r)
                begin
                    cur_nxt = req;
                    g_clear = 1'b1;
                    req_ready_nxt = 1'b0;
                    // specifier byte step (branch has none)
                    pc_nxt = req.branch ? pc_r : pc_r + 32'h1;
                    need_nxt = ext_len(req);
                    if (!req.branch && spec_reg(req.spec) != PCR_PC_REG)
                    begin
                        res_nxt = '{kind: PCR_RES_UNDEF, data: 32'h0, data_hi: 32'h0};
                        st_nxt = ST_DONE;
                    end
                    else if (!req.branch && (spec_mode(req.spec) == PCR_MODE_REG
                             || spec_mode(req.spec) == PCR_MODE_INDEX))
                    begin
                        res_nxt = '{kind: PCR_RES_UNDEF, data: pc_r, data_hi: 32'h0};
                        st_nxt = ST_DONE;
                    end
                    else if (ext_len(req) == 4'h0)
                    begin
                        res_nxt = '{kind: PCR_RES_UNDEF, data: 32'h0, data_hi: 32'h0};
                        st_nxt = ST_DONE;
                    end
                    else
                        st_nxt = ST_EXT;
                end
            end
            ST_EXT:
            begin
                if (byte_valid && g_cnt != need_r)
                begin
                    g_take = 1'b1;
                    pc_nxt = pc_r + 32'h1;
                end
                if (g_cnt == need_r)
                begin
                    // pc_r is already past the extension
                    if (cur_r.branch)
                    begin
                        res_nxt = '{kind: PCR_RES_BRANCH, data: pc_r + disp_ext,
                                    data_hi: 32'h0};
                        st_nxt = ST_DONE;
                    end
                    else
                    begin
                        case (spec_mode(cur_r.spec))
                            PCR_MODE_AINC:
                            begin
                                res_nxt = '{kind: (cur_r.access == PCR_ACC_WRITE
                                            || cur_r.access == PCR_ACC_MODIFY)
                                            ? PCR_RES_UNDEF : PCR_RES_VALUE,
                                            data: g_acc[31:0], data_hi: g_acc[63:32]};
                                st_nxt = ST_DONE;
                            end
                            PCR_MODE_AINC_DEF:
                            begin
                                res_nxt = '{kind: PCR_RES_ADDR, data: g_acc[31:0],
                                            data_hi: 32'h0};
                                st_nxt = ST_DONE;
                            end
                            PCR_MODE_BDISP_DEF, PCR_MODE_WDISP_DEF, PCR_MODE_LDISP_DEF:
                            begin
                                mem_addr_nxt = pc_r + disp_ext;
                                st_nxt = ST_INDIR;
                            end
                            default:
                            begin
                                res_nxt = '{kind: PCR_RES_ADDR, data: pc_r + disp_ext,
                                            data_hi: 32'h0};
                                st_nxt = ST_DONE;
                            end
                        endcase
                    end
                end
            end
            ST_INDIR:
            begin
                mem_req_nxt = 1'b1;
                st_nxt = ST_WAIT;
            end
            ST_WAIT:
            begin
                mem_req_nxt = !mem_ack;
                if (mem_ack)
                begin
                    res_nxt = '{kind: PCR_RES_ADDR, data: mem_rdata, data_hi: 32'h0};
                    st_nxt = ST_DONE;
                end
            end
            ST_DONE:
            begin
                res_valid_nxt = 1'b1;
                req_ready_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
            default:
                st_nxt = ST_IDLE;
        endcase
    end

    // =====================================================
    // Registers
    // =====================================================
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_r <= ST_IDLE;
            pc_r <= PCR_PC_RESET;
            cur_r <= '0;
            need_r <= 4'h0;
            req_ready_r <= 1'b0;
            mem_req_r <= 1'b0;
            mem_addr_r <= 32'h0;
            res_valid_r <= 1'b0;
            res_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
            pc_r <= pc_nxt;
            cur_r <= cur_nxt;
            need_r <= need_nxt;
            req_ready_r <= req_ready_nxt;
            mem_req_r <= mem_req_nxt;
            mem_addr_r <= mem_addr_nxt;
            res_valid_r <= res_valid_nxt;
            res_r <= res_nxt;
        end
    end

    // Byte acceptance is combinational with the stream handshake
    assign byte_take = g_take;
    assign req_ready = req_ready_r;
    assign mem_req = mem_req_r;
    assign mem_addr = mem_addr_r;
    assign res_valid = res_valid_r;
    assign res = res_r;
    assign program_counter = pc_r;
endmodule
`default_nettype wire

// ==== verilog/pcr_pkg.sv ====
package pcr_pkg;

    // =====================================================
    // Architectural constants
    // =====================================================
    // Register number that doubles as the program counter
    localparam logic [3:0] PCR_PC_REG = 4'hF;
    // Address width
    localparam int PCR_AW = 32;
    // Reset value of the program counter
    localparam logic [31:0] PCR_PC_RESET = 32'h0000_0000;

    // =====================================================
    // Operand specifier mode nibbles (upper four bits)
    // =====================================================
    localparam logic [3:0] PCR_MODE_REG = 4'h5;
    localparam logic [3:0] PCR_MODE_INDEX = 4'h4;
    localparam logic [3:0] PCR_MODE_AINC = 4'h8;
    localparam logic [3:0] PCR_MODE_AINC_DEF = 4'h9;
    localparam logic [3:0] PCR_MODE_BDISP = 4'hA;
    localparam logic [3:0] PCR_MODE_BDISP_DEF = 4'hB;
    localparam logic [3:0] PCR_MODE_WDISP = 4'hC;
    localparam logic [3:0] PCR_MODE_WDISP_DEF = 4'hD;
    localparam logic [3:0] PCR_MODE_LDISP = 4'hE;
    localparam logic [3:0] PCR_MODE_LDISP_DEF = 4'hF;

    // Field positions inside a specifier byte
    localparam int PCR_MODE_LSB = 4;
    localparam int PCR_REG_LSB = 0;

    // =====================================================
    // Operand size codes (bytes = 1 << code)
    // =====================================================
    typedef enum logic [1:0] {
        PCR_SZ_BYTE,
        PCR_SZ_WORD,
        PCR_SZ_LONG,
        PCR_SZ_QUAD
    } pcr_size_t;

    // Operand access kinds
    typedef enum logic [1:0] {
        PCR_ACC_READ,
        PCR_ACC_WRITE,
        PCR_ACC_MODIFY,
        PCR_ACC_ADDR
    } pcr_access_t;

    // Kind of result handed on
    typedef enum logic [1:0] {
        PCR_RES_ADDR,
        PCR_RES_VALUE,
        PCR_RES_BRANCH,
        PCR_RES_UNDEF
    } pcr_kind_t;

    // Request from decode: one specifier to evaluate
    typedef struct packed {
        logic [7:0] spec;
        pcr_size_t size;
        pcr_access_t access;
        logic branch;
        logic branch_word;
    } pcr_req_t;

    // Result toward the operand access path
    typedef struct packed {
        pcr_kind_t kind;
        logic [31:0] data;
        logic [31:0] data_hi;
    } pcr_res_t;

endpackage

// ==== verilog/pcr_sext.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcr_sext
(
    input wire logic [31:0] raw,
    input wire logic [1:0] nbytes_log,
    output logic [31:0] ext
);
    import pcr_pkg::*;

    // =====================================================
    // Sign extension of byte, word and longword fields
    // =====================================================
    always_comb
    begin
        case (nbytes_log)
            // Byte field
            2'h0: ext = {{24{raw[7]}}, raw[7:0]};
            // Word field
            2'h1: ext = {{16{raw[15]}}, raw[15:0]};
            default: ext = raw;
        endcase
    end
endmodule
`default_nettype wire

// ==== verilog/pcr_gather.sv ====
`timescale 1ns/1ps
`default_nettype none
module pcr_gather
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clear,
    input wire logic take,
    input wire logic [7:0] byte_in,
    output logic [63:0] acc,
    output logic [3:0] count
);
    import pcr_pkg::*;

    // =====================================================
    // Little-endian byte collector for stream extensions
    // =====================================================
    logic [63:0] acc_r;
    logic [63:0] acc_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;

    // Next value: lowest address lands in lowest byte
    always_comb
    begin
        acc_nxt = acc_r;
        cnt_nxt = cnt_r;
        if (clear)
        begin
            acc_nxt = 64'h0;
            cnt_nxt = 4'h0;
        end
        else if (take)
        begin
            acc_nxt[cnt_r[2:0]*8 +: 8] = byte_in;
            cnt_nxt = cnt_r + 4'h1;
        end
    end

    // Registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            acc_r <= 64'h0;
            cnt_r <= 4'h0;
        end
        else
        begin
            acc_r <= acc_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign acc = acc_r;
    assign count = cnt_r;
endmodule
`default_nettype wire

// ==== tb/pcr_eval_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====================================
// Port checker for the evaluator
module pcr_eval_properties
    import pcr_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic pc_load,
    input wire logic [31:0] pc_load_val,
    input wire logic opc_step,
    input wire logic req_valid,
    input wire pcr_pkg::pcr_req_t req,
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic req_ready,
    input wire logic byte_take,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic res_valid,
    input wire pcr_pkg::pcr_res_t res,
    input wire logic [31:0] program_counter
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Request accepted this edge
    logic take_w;
    assign take_w = req_valid && req_ready && !pc_load && !opc_step;
    a_load_pc:
    assert property (pc_load && req_ready |=> program_counter == $past(pc_load_val))
        else $error("counter load missed");
    a_opc_step_pc:
    assert property (opc_step && req_ready && !pc_load
        |=> program_counter == $past(program_counter) + 32'h1) else $error("opcode step");
    a_byte_step:
    assert property (byte_take |-> byte_valid ##1 program_counter == $past(program_counter) + 32'h1)
        else $error("byte step");
    a_idle_pc:
    assert property (req_ready && !pc_load && !opc_step && !take_w |=> $stable(program_counter))
        else $error("counter moved in idle");
    a_take_drop:
    assert property (take_w |=> !req_ready) else $error("ready after take");
    a_mem_hold:
    assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
        else $error("pointer read dropped");
    a_ack_res:
    assert property (mem_req && mem_ack |-> ##[1:4] res_valid) else $error("no result after read");
    a_reg_undef:
    assert property (take_w && !req.branch && req.spec[3:0] == PCR_PC_REG
        && (req.spec[7:4] == PCR_MODE_REG || req.spec[7:4] == PCR_MODE_INDEX)
        |-> ##2 res_valid && res.kind == PCR_RES_UNDEF) else $error("register mode result");
    // Result is a single pulse
    a_res_pulse:
    assert property (res_valid |=> !res_valid) else $error("result pulse too long");
    c_addr: cover property (res_valid && res.kind == PCR_RES_ADDR);
    c_value: cover property (res_valid && res.kind == PCR_RES_VALUE);
    c_branch: cover property (res_valid && res.kind == PCR_RES_BRANCH);
    c_ack: cover property (mem_ack);
endmodule
bind pcr_eval pcr_eval_properties u_props (.clk, .nrst, .pc_load, .pc_load_val, .opc_step,
    .req_valid, .req, .byte_valid, .byte_data, .mem_ack, .mem_rdata, .req_ready, .byte_take,
    .mem_req, .mem_addr, .res_valid, .res, .program_counter);
`default_nettype wire

// ==== tb/pcr_fetch_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====================================
// Stream fetch and pointer memory model
module pcr_fetch_model
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [31:0] program_counter,
    input wire logic mem_req,
    input wire logic [31:0] mem_addr,
    input wire logic slow,
    input wire logic [3:0] lat,
    output logic byte_valid,
    output logic [7:0] byte_data,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [7:0] strm [0:255]; // Stream bytes, low address bits only
    logic [3:0] cnt; // Read latency count
    logic done; // Answer given, wait for release
    logic [7:0] cur;
    logic [31:0] ptr;
    assign cur = strm[program_counter[7:0]];
    assign ptr = mem_addr ^ 32'h1234_0000;
    // Invert when not offered so a stale value never looks right
    assign byte_data = byte_valid ? cur : ~cur;
    assign mem_rdata = mem_ack ? ptr : ~ptr;
    // Drive off the falling edge; slow mode stalls every other cycle
    always @(negedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            byte_valid <= 1'b0;
            mem_ack <= 1'b0;
            cnt <= 4'h0;
            done <= 1'b0;
        end
        else
        begin
            byte_valid <= slow ? ~byte_valid : 1'b1;
            if (!mem_req)
            begin
                cnt <= 4'h0;
                done <= 1'b0;
                mem_ack <= 1'b0;
            end
            else if (mem_ack)
            begin
                mem_ack <= 1'b0;
                done <= 1'b1;
            end
            else if (!done)
            begin
                mem_ack <= (cnt >= lat);
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====================================
// Self-checking bench
module testbench;
    import pcr_pkg::*;
    logic clk, nrst, pc_load, opc_step, req_valid, byte_valid, mem_ack, slow;
    logic req_ready, byte_take, mem_req, res_valid;
    logic [31:0] pc_load_val, mem_rdata, mem_addr, program_counter, last_ma, pc_got;
    logic [7:0] byte_data;
    logic [3:0] lat;
    pcr_req_t req;
    pcr_res_t res, r_got;
    int bad_count, n_tests;
    pcr_eval dut (.clk, .nrst, .pc_load, .pc_load_val, .opc_step, .req_valid, .req,
        .byte_valid, .byte_data, .mem_ack, .mem_rdata, .req_ready, .byte_take, .mem_req,
        .mem_addr, .res_valid, .res, .program_counter);
    pcr_fetch_model part (.clk, .nrst, .program_counter, .mem_req, .mem_addr, .slow, .lat,
        .byte_valid, .byte_data, .mem_ack, .mem_rdata);
    always #25 clk = ~clk;
    // Remember the pointer address when answered
    always @(posedge clk)
        if (mem_ack === 1'b1)
            last_ma <= mem_addr;
    // ====================================
    // Shared tasks
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %s exp=%h seen=%h", nm, exp, seen);
        end
    endtask
    task test_done;
        $display("checks=%0d bad=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Bounded wait for ready or result
    task await(input bit rv);
        for (int i = 0; (rv ? res_valid : req_ready) !== 1'b1; i++)
        begin
            if (i == 80)
            begin
                bad_count++;
                test_done;
            end
            @(negedge clk);
        end
    endtask
    // Place extension, load counter, step opcode, request, take result
    task op(input logic [7:0] sp, input pcr_size_t sz, input pcr_access_t ac, input logic br,
            input logic bw, input int nb, input logic [31:0] ext, input logic [31:0] p);
        logic [31:0] a;
        a = p + (br ? 32'h1 : 32'h2);
        for (int i = 0; i < nb; i++)
            part.strm[8'(a + 32'(i))] = ext[8 * i +: 8];
        await(1'b0);
        pc_load = 1'b1;
        pc_load_val = p;
        @(negedge clk);
        pc_load = 1'b0;
        opc_step = 1'b1;
        @(negedge clk);
        opc_step = 1'b0;
        req = '{sp, sz, ac, br, bw};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        await(1'b1);
        r_got = res;
        pc_got = program_counter;
    endtask
    task ck(input pcr_kind_t k, input logic [31:0] d, input logic [31:0] p);
        chk("kind", {30'h0, r_got.kind}, {30'h0, k});
        chk("data", r_got.data, d);
        chk("counter", pc_got, p);
    endtask
    // ====================================
    // Scenarios
    task s_rel_byte;
        op(8'hAF, PCR_SZ_LONG, PCR_ACC_READ, 1'b0, 1'b0, 1, 32'h4D, 32'h2000);
        ck(PCR_RES_ADDR, 32'h2050, 32'h2003);
    endtask
    task s_rel_word_long;
        op(8'hCF, PCR_SZ_LONG, PCR_ACC_READ, 1'b0, 1'b0, 2, 32'hFF00, 32'h1000);
        ck(PCR_RES_ADDR, 32'h0F04, 32'h1004);
        op(8'hEF, PCR_SZ_LONG, PCR_ACC_ADDR, 1'b0, 1'b0, 4, 32'h1000, 32'h1010);
        ck(PCR_RES_ADDR, 32'h2016, 32'h1016);
    endtask
    // Slow stream and slow memory
    task s_rel_deferred;
        slow = 1'b1;
        lat = 4'h5;
        op(8'hBF, PCR_SZ_LONG, PCR_ACC_READ, 1'b0, 1'b0, 1, 32'h4D, 32'h2000);
        ck(PCR_RES_ADDR, 32'h1234_2050, 32'h2003);
        chk("ptr addr", last_ma, 32'h2050);
        op(8'hDF, PCR_SZ_WORD, PCR_ACC_WRITE, 1'b0, 1'b0, 2, 32'hFFF0, 32'h3000);
        ck(PCR_RES_ADDR, 32'h1234_2FF4, 32'h3004);
        chk("ptr addr", last_ma, 32'h2FF4);
        // Longword deferred form, the last displacement width
        op(8'hFF, PCR_SZ_LONG, PCR_ACC_READ, 1'b0, 1'b0, 4, 32'h0000_0100, 32'h0700);
        ck(PCR_RES_ADDR, 32'h1234_0806, 32'h0706);
        chk("ptr addr", last_ma, 32'h0806);
        slow = 1'b0;
        lat = 4'h0;
    endtask
    task s_absolute;
        op(8'h9F, PCR_SZ_LONG, PCR_ACC_WRITE, 1'b0, 1'b0, 4, 32'h0067_4533, 32'h0100);
        ck(PCR_RES_ADDR, 32'h0067_4533, 32'h0106);
    endtask
    task s_immediate;
        op(8'h8F, PCR_SZ_LONG, PCR_ACC_READ, 1'b0, 1'b0, 4, 32'h6, 32'h0200);
        ck(PCR_RES_VALUE, 32'h6, 32'h0206);
        op(8'h8F, PCR_SZ_WORD, PCR_ACC_WRITE, 1'b0, 1'b0, 2, 32'h1234, 32'h0300);
        chk("kind", {30'h0, r_got.kind}, {30'h0, PCR_RES_UNDEF});
        op(8'h8F, PCR_SZ_BYTE, PCR_ACC_MODIFY, 1'b0, 1'b0, 1, 32'h12, 32'h0310);
        chk("kind", {30'h0, r_got.kind}, {30'h0, PCR_RES_UNDEF});
        // Quad immediate: upper longword placed by hand past the low one
        part.strm[8'h06] = 8'hD4;
        part.strm[8'h07] = 8'hC3;
        part.strm[8'h08] = 8'hB2;
        part.strm[8'h09] = 8'hA1;
        op(8'h8F, PCR_SZ_QUAD, PCR_ACC_READ, 1'b0, 1'b0, 4, 32'h6, 32'h0600);
        ck(PCR_RES_VALUE, 32'h6, 32'h060A);
        chk("data hi", r_got.data_hi, 32'hA1B2_C3D4);
    endtask
    task s_reg_index;
        op(8'h5F, PCR_SZ_LONG, PCR_ACC_READ, 1'b0, 1'b0, 0, 32'h0, 32'h0500);
        chk("kind", {30'h0, r_got.kind}, {30'h0, PCR_RES_UNDEF});
        op(8'h4F, PCR_SZ_LONG, PCR_ACC_READ, 1'b0, 1'b0, 0, 32'h0, 32'h0510);
        chk("kind", {30'h0, r_got.kind}, {30'h0, PCR_RES_UNDEF});
        op(8'hA3, PCR_SZ_LONG, PCR_ACC_READ, 1'b0, 1'b0, 0, 32'h0, 32'h0520);
        chk("kind", {30'h0, r_got.kind}, {30'h0, PCR_RES_UNDEF});
    endtask
    task s_branch;
        op(8'h00, PCR_SZ_BYTE, PCR_ACC_READ, 1'b1, 1'b0, 1, 32'h80, 32'h0400);
        ck(PCR_RES_BRANCH, 32'h0382, 32'h0402);
        op(8'h00, PCR_SZ_WORD, PCR_ACC_READ, 1'b1, 1'b1, 2, 32'h7FFF, 32'h0400);
        ck(PCR_RES_BRANCH, 32'h8402, 32'h0403);
    endtask
    // ====================================
    // Main sequence
    initial
    begin
        clk = 1'b0;
        nrst = 1'b0;
        pc_load = 1'b0;
        pc_load_val = 32'h0;
        opc_step = 1'b0;
        req_valid = 1'b0;
        req = '0;
        slow = 1'b0;
        lat = 4'h0;
        bad_count = 0;
        n_tests = 0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        s_rel_byte;
        s_rel_word_long;
        s_rel_deferred;
        s_absolute;
        s_immediate;
        s_reg_index;
        s_branch;
        test_done;
    end
endmodule
`default_nettype wire
